// ---- core/mtl_pkg.sv ----
// Notes on behaviour
// - During a coordinated move, hold the next command until path reaches target.
// - Path distance counts quadrature counts from sequence start or last trippoint.
// - Trippoint distance is unsigned, zero to largest positive 32-bit; default zero.
// - Distance operand returns path since sequence start; valid in linear/vector mode.
// - Begin starts named axes, the sequence, or both in one command.
// - Bit seven of each axis first status word shows motion in progress.
// - Running operand reads one while moving and zero once complete.
// - Axis past reverse limit decelerates to stop; further reverse motion refused.
// - Reverse limit acts one count below programmed value, in quadrature counts.
// - Limit is signed 32-bit; most negative value disables it; disabled by default.
// - Limit query and limit operand both return the programmed limit.
// - Parameter save writes flash in about one second, then returns colon.
// - Parameter save converts legacy zero to derivative, legacy gain to proportional.
// - Save operand returns the serial number, not any save status.
// - Program save takes up to ten seconds, uninterrupted, then returns colon.
package mtl_pkg;

  localparam int           NAX           = 4;
  localparam int           STAT_RUN_BIT  = 7;
  localparam logic [31:0]  VDIST_RST     = 32'h0000_0000;
  localparam logic [31:0]  RLIM_OFF      = 32'h8000_0000;
  localparam logic [15:0]  GAIN_RST      = 16'h0000;
  // Arbitrary serial number value
  localparam logic [31:0]  SERIAL_RST    = 32'h0000_5A17;

  localparam longint       CLK_HZ        = 200000000;
  localparam longint       PSAVE_MS      = 1000;
  localparam longint       PPROG_MS      = 10000;
  localparam longint       PSAVE_CYC     = (PSAVE_MS * CLK_HZ) / 1000;
  localparam longint       PPROG_CYC     = (PPROG_MS * CLK_HZ) / 1000;

  typedef enum logic [2:0] {
    CMD_VECTOR_DISTANCE_TRIP,
    CMD_BEGIN_MOTION,
    CMD_REVERSE_SOFT_LIMIT,
    CMD_PARAMETER_SAVE,
    CMD_PROGRAM_SAVE
  } mtl_cmd_t;

  typedef enum logic [1:0] {
    QRY_VECTOR_DISTANCE,
    QRY_MOTION_RUNNING,
    QRY_REVERSE_LIMIT,
    QRY_SERIAL_NUMBER
  } mtl_qry_t;

endpackage

// ---- core/mtl_burn_timer.sv ----
module mtl_burn_timer
  import mtl_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        start_i,
  input  wire logic [31:0] len_i,
  // Status
  output logic             busy_o,
  output logic             done_o
);

  logic [31:0] cnt_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= 32'h0000_0000;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt_r  <= len_i;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      // A zero length still takes one cycle
      if (cnt_r <= 32'h0000_0001) begin
        busy_o <= 1'b0;
      end
      cnt_r <= cnt_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && !start_i && (cnt_r <= 32'h0000_0001);
    end
  end

endmodule

// ---- core/mtl_rev_limit.sv ----
module mtl_rev_limit
  import mtl_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Axis state
  input  wire logic [31:0] pos_i,
  input  wire logic [31:0] lim_i,
  input  wire logic        moving_i,
  // Limit actions
  output logic             block_o,
  output logic             decel_o
);

  logic past_w;

  assign past_w = (lim_i != RLIM_OFF) && ($signed(pos_i) < $signed(lim_i));

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      block_o <= 1'b0;
      decel_o <= 1'b0;
    end else begin
      block_o <= past_w;
      decel_o <= past_w && moving_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_rev_trip_point: assert property (
    (lim_i != RLIM_OFF && $signed(pos_i) == $signed(lim_i) - 1)
      |=> block_o)
    else $error("limit not active one count below value");
  a_rev_disabled: assert property (
    (lim_i == RLIM_OFF) |=> !block_o && !decel_o)
    else $error("disabled limit acted");
  a_rev_decel: assert property (
    (past_w && moving_i) |=> decel_o ##0 block_o)
    else $error("no deceleration past limit");
  a_rev_inside: assert property (
    (lim_i != RLIM_OFF && $signed(pos_i) >= $signed(lim_i)) |=> !block_o)
    else $error("limit acted inside range");

endmodule

// ---- core/mtl_cmd_core.sv ----
module mtl_cmd_core
  import mtl_pkg::*;
#(
  parameter logic [31:0] PSAVE_CYCLES = 32'(PSAVE_CYC),
  parameter logic [31:0] PPROG_CYCLES = 32'(PPROG_CYC)
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  // Command
  input  wire logic                    cmd_valid_i,
  input  wire mtl_cmd_t                cmd_code_i,
  input  wire logic [NAX-1:0]          cmd_axes_i,
  input  wire logic                    cmd_seq_i,
  input  wire logic [1:0]              cmd_axis_i,
  input  wire logic [31:0]             cmd_arg_i,
  output logic                         cmd_ready_o,
  output logic                         colon_o,
  // Operand query
  input  wire logic                    qry_valid_i,
  input  wire mtl_qry_t                qry_code_i,
  input  wire logic [1:0]              qry_axis_i,
  input  wire logic                    qry_seq_i,
  output logic                         qry_valid_o,
  output logic [31:0]                  qry_data_o,
  // Profiler
  input  wire logic [NAX-1:0]          axis_moving_i,
  input  wire logic                    seq_moving_i,
  input  wire logic                    path_count_i,
  input  wire logic                    linear_interp_mode_i,
  input  wire logic                    vector_mode_i,
  input  wire logic [NAX-1:0][31:0]    axis_pos_i,
  output logic [NAX-1:0]               axis_start_o,
  output logic                         seq_start_o,
  output logic [NAX-1:0]               axis_decel_o,
  output logic [NAX-1:0]               rev_block_o,
  output logic [NAX-1:0][7:0]          axis_status1_o,
  // Flash save
  input  wire logic [15:0]             legacy_zero_value_i,
  input  wire logic [15:0]             legacy_gain_value_i,
  output logic                         flash_write_o,
  output logic                         flash_program_o,
  output logic [15:0]                  derivative_gain_o,
  output logic [15:0]                  proportional_gain_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_TRIP_WAIT, ST_SAVE} mtl_state_t;

  mtl_state_t           state_r;
  mtl_state_t           state_nxt;
  logic                 take_w;
  logic                 trip_hit_w;
  logic [31:0]          trip_target_r;
  logic [31:0]          seg_dist_r;
  logic [31:0]          total_dist_r;
  logic [NAX-1:0]       run_r;
  logic [NAX-1:0]       run_nxt;
  logic [NAX-1:0]       mov_q_r;
  logic [NAX-1:0]       begin_w;
  logic                 seq_run_r;
  logic                 seq_mov_q_r;
  logic                 seq_begin_w;
  logic [NAX-1:0][31:0] rlim_r;
  logic                 burn_start_r;
  logic [31:0]          burn_len_r;
  logic                 burn_busy_w;
  logic                 burn_done_w;
  logic                 sel_run_w;
  logic [31:0]          sel_rlim_w;

  assign take_w = cmd_valid_i && cmd_ready_o;

  assign trip_hit_w = (seg_dist_r >= trip_target_r) || !seq_run_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take_w && cmd_code_i == CMD_VECTOR_DISTANCE_TRIP) begin
          state_nxt = ST_TRIP_WAIT;
        end else if (take_w && (cmd_code_i == CMD_PARAMETER_SAVE ||
                                cmd_code_i == CMD_PROGRAM_SAVE)) begin
          state_nxt = ST_SAVE;
        end
      end
      ST_TRIP_WAIT: begin
        if (trip_hit_w) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SAVE: begin
        if (burn_done_w) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      cmd_ready_o <= 1'b0;
      colon_o     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cmd_ready_o <= (state_nxt == ST_IDLE);
      colon_o     <= burn_done_w;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trip_target_r <= VDIST_RST;
    end else if (take_w && cmd_code_i == CMD_VECTOR_DISTANCE_TRIP) begin
      trip_target_r <= {1'b0, cmd_arg_i[30:0]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seg_dist_r   <= 32'h0000_0000;
      total_dist_r <= 32'h0000_0000;
    end else begin
      if (seq_start_o || (state_r == ST_TRIP_WAIT && trip_hit_w)) begin
        seg_dist_r <= {31'h0, path_count_i};
      end else if (path_count_i) begin
        seg_dist_r <= seg_dist_r + 32'h0000_0001;
      end
      if (seq_start_o) begin
        total_dist_r <= {31'h0, path_count_i};
      end else if (path_count_i) begin
        total_dist_r <= total_dist_r + 32'h0000_0001;
      end
    end
  end

  assign begin_w     = (take_w && cmd_code_i == CMD_BEGIN_MOTION) ?
                       (cmd_axes_i & ~run_r) : '0;
  assign seq_begin_w = take_w && cmd_code_i == CMD_BEGIN_MOTION &&
                       cmd_seq_i && !seq_run_r;

  // A fresh begin wins over a motion-end edge
  always_comb begin
    run_nxt = run_r;
    for (int a = 0; a < NAX; a++) begin
      if (begin_w[a]) begin
        run_nxt[a] = 1'b1;
      end else if (mov_q_r[a] && !axis_moving_i[a]) begin
        run_nxt[a] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r          <= '0;
      mov_q_r        <= '0;
      axis_start_o   <= '0;
      axis_status1_o <= '0;
    end else begin
      run_r        <= run_nxt;
      mov_q_r      <= axis_moving_i;
      axis_start_o <= begin_w;
      for (int a = 0; a < NAX; a++) begin
        axis_status1_o[a]               <= 8'h00;
        axis_status1_o[a][STAT_RUN_BIT] <= run_nxt[a];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_run_r   <= 1'b0;
      seq_mov_q_r <= 1'b0;
      seq_start_o <= 1'b0;
    end else begin
      seq_mov_q_r <= seq_moving_i;
      seq_start_o <= seq_begin_w;
      if (seq_begin_w) begin
        seq_run_r <= 1'b1;
      end else if (seq_mov_q_r && !seq_moving_i) begin
        seq_run_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rlim_r <= {NAX{RLIM_OFF}};
    end else if (take_w && cmd_code_i == CMD_REVERSE_SOFT_LIMIT) begin
      rlim_r[cmd_axis_i] <= cmd_arg_i;
    end
  end

  generate
    for (genvar g = 0; g < NAX; g++) begin : g_rlim
      mtl_rev_limit u_rlim (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pos_i     (axis_pos_i[g]),
        .lim_i     (rlim_r[g]),
        .moving_i  (axis_moving_i[g]),
        .block_o   (rev_block_o[g]),
        .decel_o   (axis_decel_o[g])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      burn_start_r        <= 1'b0;
      burn_len_r          <= 32'h0000_0000;
      flash_write_o       <= 1'b0;
      flash_program_o     <= 1'b0;
      derivative_gain_o   <= GAIN_RST;
      proportional_gain_o <= GAIN_RST;
    end else begin
      burn_start_r <= 1'b0;
      if (burn_done_w) begin
        flash_write_o <= 1'b0;
      end
      if (take_w && cmd_code_i == CMD_PARAMETER_SAVE) begin
        burn_start_r        <= 1'b1;
        burn_len_r          <= PSAVE_CYCLES;
        flash_write_o       <= 1'b1;
        flash_program_o     <= 1'b0;
        derivative_gain_o   <= legacy_zero_value_i;
        proportional_gain_o <= legacy_gain_value_i;
      end else if (take_w && cmd_code_i == CMD_PROGRAM_SAVE) begin
        burn_start_r    <= 1'b1;
        burn_len_r      <= PPROG_CYCLES;
        flash_write_o   <= 1'b1;
        flash_program_o <= 1'b1;
      end
    end
  end

  mtl_burn_timer u_burn (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (burn_start_r),
    .len_i     (burn_len_r),
    .busy_o    (burn_busy_w),
    .done_o    (burn_done_w)
  );

  assign sel_run_w  = qry_seq_i ? seq_run_r : run_r[qry_axis_i];
  assign sel_rlim_w = rlim_r[qry_axis_i];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qry_valid_o <= 1'b0;
      qry_data_o  <= 32'h0000_0000;
    end else begin
      qry_valid_o <= qry_valid_i;
      if (qry_valid_i) begin
        unique case (qry_code_i)
          QRY_VECTOR_DISTANCE:
            qry_data_o <= (linear_interp_mode_i || vector_mode_i) ?
                          total_dist_r : 32'h0000_0000;
          QRY_MOTION_RUNNING: qry_data_o <= {31'h0, sel_run_w};
          QRY_REVERSE_LIMIT:  qry_data_o <= sel_rlim_w;
          QRY_SERIAL_NUMBER:  qry_data_o <= SERIAL_RST;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_trip_holds: assert property (
    (state_r == ST_TRIP_WAIT && seq_run_r && seg_dist_r < trip_target_r)
      |=> !cmd_ready_o)
    else $error("trippoint did not stall commands");
  a_trip_release: assert property (
    (state_r == ST_TRIP_WAIT && trip_hit_w) |=> cmd_ready_o)
    else $error("trippoint not released at target");
  a_seg_restart: assert property (
    seq_start_o |=> seg_dist_r <= 32'h0000_0001)
    else $error("path count not restarted at sequence start");
  a_target_range: assert property (
    !trip_target_r[31])
    else $error("trippoint target above positive range");
  a_dist_mode: assert property (
    (qry_valid_i && qry_code_i == QRY_VECTOR_DISTANCE &&
     !linear_interp_mode_i && !vector_mode_i) |=> qry_data_o == 32'h0)
    else $error("distance returned outside interp modes");
  a_begin_status: assert property (
    begin_w[0] |=> axis_start_o[0] && axis_status1_o[0][STAT_RUN_BIT])
    else $error("begin did not raise motion status");
  a_run_query: assert property (
    (qry_valid_i && qry_code_i == QRY_MOTION_RUNNING)
      |=> qry_valid_o && qry_data_o == {31'h0, $past(sel_run_w)})
    else $error("running operand wrong");
  a_rlim_query: assert property (
    (qry_valid_i && qry_code_i == QRY_REVERSE_LIMIT)
      |=> qry_data_o == $past(sel_rlim_w))
    else $error("limit operand wrong");
  a_serial_query: assert property (
    (qry_valid_i && qry_code_i == QRY_SERIAL_NUMBER)
      |=> qry_data_o == SERIAL_RST)
    else $error("save operand not serial number");
  a_save_busy: assert property (
    (take_w && cmd_code_i == CMD_PROGRAM_SAVE) |=> !cmd_ready_o [*3])
    else $error("program save interrupted");
  a_gain_conv: assert property (
    (take_w && cmd_code_i == CMD_PARAMETER_SAVE)
      |=> derivative_gain_o == $past(legacy_zero_value_i) &&
          proportional_gain_o == $past(legacy_gain_value_i))
    else $error("legacy zero not converted");
  a_colon_end: assert property (
    colon_o |-> cmd_ready_o && !flash_write_o)
    else $error("colon before save end");

  c_trip_done: cover property (state_r == ST_TRIP_WAIT ##1 state_r == ST_IDLE);
  c_seq_axes: cover property (seq_start_o && axis_start_o[1]);
  c_limit_hit: cover property (axis_decel_o[0]);
  c_save_done: cover property (colon_o);

endmodule

// ---- tb/mtl_prof_model.sv ----
module mtl_prof_model
  import mtl_pkg::*;
#(
  parameter int RUN = 20
) (
  // Clock and reset
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  // Start pulses
  input  wire logic [NAX-1:0] axis_start_i,
  input  wire logic           seq_start_i,
  // Motion state
  output logic [NAX-1:0]      axis_moving_o,
  output logic                seq_moving_o,
  output logic                path_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [NAX+1];

  // Index NAX is the coordinated sequence
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '{default: 0};
    end else begin
      for (int i = 0; i <= NAX; i++) begin
        if ((i < NAX) ? axis_start_i[i] : seq_start_i) begin
          cnt[i] <= RUN;
        end else if (cnt[i] > 0) begin
          cnt[i] <= cnt[i] - 1;
        end
      end
    end
  end

  // One path count per cycle of sequence motion
  always_comb begin
    for (int i = 0; i < NAX; i++) begin
      axis_moving_o[i] = (cnt[i] != 0);
    end
    seq_moving_o = (cnt[NAX] != 0);
    path_count_o = seq_moving_o;
  end
endmodule

// ---- tb/tb_top.sv ----
module tb_top
  import mtl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PS  = 20;
  localparam int PP  = 40;
  localparam int RUN = 20;

  logic             ref_clk_i = 1'b0;
  logic             rst_i     = 1'b1;
  logic             cv        = 1'b0;
  mtl_cmd_t         cc        = CMD_BEGIN_MOTION;
  logic [3:0]       cax       = 4'h0;
  logic             cs        = 1'b0;
  logic [1:0]       cai       = 2'h0;
  logic [31:0]      carg      = 32'h0;
  logic             qv        = 1'b0;
  mtl_qry_t         qc        = QRY_SERIAL_NUMBER;
  logic [1:0]       qa        = 2'h0;
  logic             qs        = 1'b0;
  logic             lm        = 1'b0;
  logic             vm        = 1'b0;
  logic [3:0][31:0] pos       = '0;
  logic [15:0]      lz        = 16'h1234;
  logic [15:0]      lg        = 16'h5678;
  logic             rdy, colon, qvo, smov, pc, sst, fw, fp;
  logic [31:0]      rd, qd;
  logic [3:0]       mov, ast, dec, blk;
  logic [3:0][7:0]  st;
  logic [15:0]      kd, kp;
  int               err_total, samples_checked, npath, p1, p2;

  always #2.5 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    if (sst) npath <= 0;
    else if (pc) npath <= npath + 1;
  end

  mtl_cmd_core #(.PSAVE_CYCLES(32'(PS)), .PPROG_CYCLES(32'(PP)))
  mtl_cmd_core_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_axes_i(cax),
    .cmd_seq_i(cs), .cmd_axis_i(cai), .cmd_arg_i(carg),
    .cmd_ready_o(rdy), .colon_o(colon),
    .qry_valid_i(qv), .qry_code_i(qc), .qry_axis_i(qa),
    .qry_seq_i(qs), .qry_valid_o(qvo), .qry_data_o(qd),
    .axis_moving_i(mov), .seq_moving_i(smov), .path_count_i(pc),
    .linear_interp_mode_i(lm), .vector_mode_i(vm), .axis_pos_i(pos),
    .axis_start_o(ast), .seq_start_o(sst), .axis_decel_o(dec),
    .rev_block_o(blk), .axis_status1_o(st),
    .legacy_zero_value_i(lz), .legacy_gain_value_i(lg),
    .flash_write_o(fw), .flash_program_o(fp),
    .derivative_gain_o(kd), .proportional_gain_o(kp)
  );

  mtl_prof_model #(.RUN(RUN)) mtl_prof_model_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .axis_start_i(ast), .seq_start_i(sst),
    .axis_moving_o(mov), .seq_moving_o(smov), .path_count_o(pc)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic until_rdy(input int lim);
    int k;
    k = 0;
    while (rdy !== 1'b1) begin
      tick(1);
      k++;
      if (k > lim) begin
        err_total++;
        report_and_stop;
      end
    end
  endtask

  // Returns at the falling edge half a cycle after the take edge
  task automatic cmd(input mtl_cmd_t c, input logic [3:0] ax,
                     input logic s, input logic [1:0] ai,
                     input logic [31:0] a);
    until_rdy(200);
    cv = 1'b1;
    cc = c;
    cax = ax;
    cs = s;
    cai = ai;
    carg = a;
    tick(1);
    cv = 1'b0;
  endtask

  task automatic qry(input mtl_qry_t c, input logic [1:0] ai,
                     input logic s);
    qv = 1'b1;
    qc = c;
    qa = ai;
    qs = s;
    tick(1);
    qv = 1'b0;
    chk("qry_valid", qvo, 1);
    rd = qd;
    tick(1);
  endtask

  // Host holds off until profiler motion is over
  task automatic wait_idle;
    int k;
    for (k = 0; k < 200 && (mov !== 4'h0 || smov !== 1'b0); k++) tick(1);
    chk("idle_wait", k < 200, 1);
    if (k >= 200) report_and_stop;
    else tick(2);
  endtask

  task automatic save(input mtl_cmd_t c, input int len, input logic pr);
    int k;
    logic hit;
    cmd(c, 4'h0, 1'b0, 2'h0, 32'h0);
    chk("flash_wr", fw, 1);
    chk("flash_prog", fp, pr);
    chk("rdy_busy", rdy, 0);
    k = 1;
    hit = 1'b0;
    while (colon !== 1'b1 && k < len + 10) begin
      if (k == 3) begin
        cv = 1'b1;
        cc = CMD_BEGIN_MOTION;
        cax = 4'b0100;
      end
      if (k == 6) cv = 1'b0;
      tick(1);
      k++;
      if (ast[2] === 1'b1) hit = 1'b1;
    end
    chk("colon_at", k, len + 3);
    if (colon !== 1'b1) begin
      report_and_stop;
    end else begin
      chk("refused", hit, 0);
      chk("flash_end", fw, 0);
      chk("rdy_end", rdy, 1);
      tick(1);
      chk("colon_pulse", colon, 0);
    end
  endtask

  initial begin
    tick(2);
    rst_i = 1'b0;
    tick(1);
    qry(QRY_REVERSE_LIMIT, 2'h3, 1'b0);
    chk("lim_rst", rd, RLIM_OFF);
    qry(QRY_SERIAL_NUMBER, 2'h0, 1'b0);
    chk("serial", rd, SERIAL_RST);
    cmd(CMD_BEGIN_MOTION, 4'h1, 1'b1, 2'h0, 32'h0);
    chk("axis_start", ast, 4'h1);
    chk("seq_start", sst, 1);
    chk("status_run", st[0], 8'h80);
    tick(1);
    qry(QRY_MOTION_RUNNING, 2'h0, 1'b0);
    chk("run_axis", rd, 1);
    qry(QRY_MOTION_RUNNING, 2'h0, 1'b1);
    chk("run_seq", rd, 1);
    wait_idle;
    chk("status_done", st[0], 8'h00);
    qry(QRY_MOTION_RUNNING, 2'h0, 1'b0);
    chk("done_axis", rd, 0);
    qry(QRY_MOTION_RUNNING, 2'h0, 1'b1);
    chk("done_seq", rd, 0);
    for (int m = 0; m < 3; m++) begin
      lm = (m == 1);
      vm = (m == 2);
      qry(QRY_VECTOR_DISTANCE, 2'h0, 1'b0);
      chk("dist", rd, (m == 0) ? 32'h0 : 32'(RUN));
    end
    cmd(CMD_BEGIN_MOTION, 4'h0, 1'b1, 2'h0, 32'h0);
    tick(1);
    cmd(CMD_VECTOR_DISTANCE_TRIP, 4'h0, 1'b0, 2'h0, 32'h5);
    chk("trip_hold", rdy, 0);
    until_rdy(RUN);
    p1 = npath;
    chk("trip1", p1 >= 5 && p1 <= 7, 1);
    cmd(CMD_VECTOR_DISTANCE_TRIP, 4'h0, 1'b0, 2'h0, 32'h3);
    until_rdy(RUN);
    p2 = npath;
    chk("trip2", p2 - p1 >= 3 && p2 - p1 <= 5, 1);
    wait_idle;
    cmd(CMD_VECTOR_DISTANCE_TRIP, 4'h0, 1'b0, 2'h0, 32'h7FFF_FFFF);
    until_rdy(10);
    chk("trip_max", rdy, 1);
    pos[1] = 32'hFFFF_FFFB;
    cmd(CMD_REVERSE_SOFT_LIMIT, 4'h0, 1'b0, 2'h1, 32'hFFFF_FFFB);
    tick(2);
    qry(QRY_REVERSE_LIMIT, 2'h1, 1'b0);
    chk("lim_qry", rd, 32'hFFFF_FFFB);
    chk("blk_at", blk, 4'h0);
    pos[1] = 32'hFFFF_FFFA;
    tick(2);
    chk("blk_below", blk, 4'h2);
    chk("dec_still", dec, 4'h0);
    cmd(CMD_BEGIN_MOTION, 4'h2, 1'b0, 2'h0, 32'h0);
    tick(4);
    chk("dec_move", dec, 4'h2);
    wait_idle;
    pos[1] = 32'h8000_0000;
    cmd(CMD_REVERSE_SOFT_LIMIT, 4'h0, 1'b0, 2'h1, RLIM_OFF);
    tick(2);
    chk("blk_off", blk, 4'h0);
    save(CMD_PARAMETER_SAVE, PS, 1'b0);
    chk("kd", kd, lz);
    chk("kp", kp, lg);
    save(CMD_PROGRAM_SAVE, PP, 1'b1);
    report_and_stop;
  end
endmodule
